// ### ncsac_params.svh
`ifndef NCSAC_PARAMS_SVH
`define NCSAC_PARAMS_SVH
// Register byte offsets
`define NCSAC_OFF_DATL 12'h000
`define NCSAC_OFF_DATH 12'h004
`define NCSAC_OFF_ADRL 12'h008
`define NCSAC_OFF_ADRH 12'h00c
`define NCSAC_OFF_CTRL 12'h010
`define NCSAC_OFF_KEY 12'h014
// Control bit positions
`define NCSAC_B_PGM 7
`define NCSAC_B_CFG 6
`define NCSAC_B_LATCH_LOAD_ONLY 5
`define NCSAC_B_ERASE 4
`define NCSAC_B_ERR 3
`define NCSAC_B_PROGRAM_ERASE_ENABLE 2
`define NCSAC_B_WR 1
`define NCSAC_B_RD 0
// Reset and fill values
`define NCSAC_RST_BYTE 8'h00
`define NCSAC_ADRH_FILL 1'b1
`define NCSAC_DATH_FILL 2'h0
`define NCSAC_ERASED 14'h3fff
`define NCSAC_KEY1 8'h55
`define NCSAC_KEY2 8'haa
// Configuration space indices
`define NCSAC_UID_LAST 4'h3
`define NCSAC_REVID 4'h5
`define NCSAC_DEVID 4'h6
`define NCSAC_CFGW1 4'h7
`define NCSAC_CFGW2 4'h8
// Geometry
`define NCSAC_PROG_WORDS 32768
`define NCSAC_EE_BYTES 256
`define NCSAC_LATCHES 16
// Timing
`define NCSAC_CLK_NS 25
`define NCSAC_WRITE_TIME_NS 2000
`define NCSAC_WRITE_CYC ((`NCSAC_WRITE_TIME_NS + `NCSAC_CLK_NS - 1) / `NCSAC_CLK_NS)
`endif

// ### ncsac_pkg.sv
package ncsac_pkg;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} ncsac_state_e;
  typedef enum logic [1:0] {
    OP_LATCH = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10,
    OP_EE    = 2'b11
  } ncsac_op_e;
  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } ncsac_key_e;
endpackage

// ### ncsac_top.sv
// How it works
// - Config select one steers reads and writes to the config region.
// - Config read of an unlisted address clears both data registers.
// - User IDs read and write; revision, device ID, config words read only.
// - Low data is byte or bits 7:0; high data bits 5:0, top two read zero.
// - High address bits 6:0 give address 14:8; its bit 7 reads one.
// - With config clear, program select picks Flash, else data EEPROM.
// - Latch-only strobe just loads one write latch, no programming.
// - Normal strobe loads the latch then programs all latched words.
// - EEPROM target ignores latch-only and erase; strobe erases then writes.
// - Erase select makes the strobe erase; hardware clears it when done.
// - Error flag set on bad sequence or abort; cleared on normal finish.
// - Enable bit clear blocks every program and erase cycle.
// - Write start runs a self-timed operation; cleared by hardware when done.
// - Software can only set write start, never clear it.
// - Read start loads data in one cycle; hardware clears, software only sets.
// - Processor halts during a Flash or config write until done.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ncsac_params.svh"
module ncsac_top
  import ncsac_pkg::*;
#(
  parameter logic [13:0] REV_ID  = 14'h0001, // Arbitrary value
  parameter logic [13:0] DEV_ID  = 14'h0a5a, // Arbitrary value
  parameter logic [13:0] CFG_W1  = 14'h3fff,
  parameter logic [13:0] CFG_W2  = 14'h3fff
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Processor halt
  output logic             CPU_HALT
);
  function automatic logic cfg_readable(input logic [14:0] a);
    cfg_readable = (a[14:4] == 11'h000) && (a[3:0] <= `NCSAC_CFGW2)
                   && (a[3:0] != 4'h4);
  endfunction
  function automatic logic [13:0] row_word(input ncsac_op_e op, input logic [13:0] w);
    row_word = (op == OP_ERASE) ? `NCSAC_ERASED : w;
  endfunction
  function automatic logic cfg_writable(input logic [14:0] a);
    cfg_writable = (a[14:4] == 11'h000) && (a[3:0] <= `NCSAC_UID_LAST);
  endfunction

  logic [7:0]   dat_lo_q;
  logic [5:0]   dat_hi_q;
  logic [7:0]   adr_lo_q;
  logic [6:0]   adr_hi_q;
  logic         pgm_q;
  logic         cfg_q;
  logic         latch_load_only_q;
  logic         erase_q;
  logic         err_q;
  logic         program_erase_enable_q;
  logic         wr_q;
  logic         rd_q;
  ncsac_key_e   key_q;
  ncsac_state_e state_q;
  ncsac_op_e    op_q;
  logic [7:0]   cnt_q;
  logic [14:0]  op_adr_q;
  logic [13:0]  op_dat_q;
  logic         op_cfg_q;
  logic         pready_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic         halt_q;
  logic         halt_d;
  logic [13:0]  prog_mem [0:`NCSAC_PROG_WORDS-1];
  logic [7:0]   ee_mem [0:`NCSAC_EE_BYTES-1];
  logic [13:0]  uid_mem [0:`NCSAC_UID_LAST];
  logic [13:0]  lat [0:`NCSAC_LATCHES-1];
  // Bus decode
  wire         setup_acc = PSEL & PENABLE & ~pready_q;
  wire         commit    = PSEL & PENABLE & pready_q;
  wire         wr_acc    = commit & PWRITE;
  wire         hit_datl  = PADDR == `NCSAC_OFF_DATL;
  wire         hit_dath  = PADDR == `NCSAC_OFF_DATH;
  wire         hit_adrl  = PADDR == `NCSAC_OFF_ADRL;
  wire         hit_adrh  = PADDR == `NCSAC_OFF_ADRH;
  wire         hit_ctrl  = PADDR == `NCSAC_OFF_CTRL;
  wire         hit_key   = PADDR == `NCSAC_OFF_KEY;
  wire         mapped    = hit_datl | hit_dath | hit_adrl | hit_adrh | hit_ctrl | hit_key;
  wire [7:0]   wd        = PWDATA[7:0];
  wire         ctl_wr    = wr_acc & hit_ctrl;
  wire [7:0]   ctl_rd    = {pgm_q, cfg_q, latch_load_only_q, erase_q, err_q, program_erase_enable_q, wr_q, rd_q};
  wire [7:0]   rd_mux    = hit_datl ? dat_lo_q :
                           hit_dath ? {`NCSAC_DATH_FILL, dat_hi_q} :
                           hit_adrl ? adr_lo_q :
                           hit_adrh ? {`NCSAC_ADRH_FILL, adr_hi_q} :
                           hit_ctrl ? ctl_rd : `NCSAC_RST_BYTE;
  // Operation decode
  wire [14:0]  addr15    = {adr_hi_q, adr_lo_q};
  wire         is_ee     = ~cfg_q & ~pgm_q;
  wire         wr_req    = ctl_wr & wd[`NCSAC_B_WR] & ~wr_q & (state_q == ST_IDLE);
  wire         wr_ok     = wr_req & program_erase_enable_q & (key_q == KEY_OPEN);
  wire         wr_bad    = wr_req & ~wr_ok;
  wire         rd_req    = ctl_wr & wd[`NCSAC_B_RD] & ~rd_q;
  wire         busy      = state_q == ST_BUSY;
  wire         abort     = busy & ~program_erase_enable_q;
  wire         done      = busy & (cnt_q == 8'h00) & program_erase_enable_q;
  wire [3:0]   slot      = addr15[3:0];
  wire [13:0]  dat14     = {dat_hi_q, dat_lo_q};
  ncsac_op_e   op_sel;
  assign op_sel = is_ee ? OP_EE : erase_q ? OP_ERASE : latch_load_only_q ? OP_LATCH : OP_PROG;
  wire [7:0]   cnt_init  = (op_sel == OP_LATCH) ? 8'h00 : 8'(`NCSAC_WRITE_CYC - 1);
  wire         cfg_ok    = cfg_readable(addr15);
  logic [13:0] cfg_word;
  always_comb begin
    case (slot)
      `NCSAC_REVID: cfg_word = REV_ID;
      `NCSAC_DEVID: cfg_word = DEV_ID;
      `NCSAC_CFGW1: cfg_word = CFG_W1;
      `NCSAC_CFGW2: cfg_word = CFG_W2;
      default:      cfg_word = uid_mem[slot[1:0]];
    endcase
  end
  wire [13:0]  rd_word   = cfg_q ? (cfg_ok ? cfg_word : 14'h0000) :
                           prog_mem[addr15];
  assign halt_d = (wr_ok & ~is_ee) | (halt_q & ~(done | abort));
  // Bus answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc & ~mapped;
      if (setup_acc & ~PWRITE) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end
  // Unlock key sequence
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      key_q <= KEY_NONE;
    end else if (wr_acc & hit_key) begin
      if (wd == `NCSAC_KEY1) begin
        key_q <= KEY_HALF;
      end else if ((wd == `NCSAC_KEY2) && (key_q == KEY_HALF)) begin
        key_q <= KEY_OPEN;
      end else begin
        key_q <= KEY_NONE;
      end
    end else if (wr_acc & (key_q != KEY_OPEN | hit_ctrl)) begin
      key_q <= KEY_NONE;
    end
  end
  // Address and data registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      adr_lo_q <= `NCSAC_RST_BYTE;
      adr_hi_q <= 7'h00;
      dat_lo_q <= `NCSAC_RST_BYTE;
      dat_hi_q <= 6'h00;
    end else begin
      if (wr_acc & hit_adrl) adr_lo_q <= wd;
      if (wr_acc & hit_adrh) adr_hi_q <= wd[6:0];
      if (wr_acc & hit_datl) dat_lo_q <= wd;
      if (wr_acc & hit_dath) dat_hi_q <= wd[5:0];
      if (rd_q) begin
        if (is_ee) begin
          dat_lo_q <= ee_mem[adr_lo_q];
        end else begin
          dat_lo_q <= rd_word[7:0];
          dat_hi_q <= rd_word[13:8];
        end
      end
    end
  end
  // Control register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pgm_q   <= 1'b0;
      cfg_q   <= 1'b0;
      latch_load_only_q  <= 1'b0;
      erase_q <= 1'b0;
      err_q   <= 1'b0;
      program_erase_enable_q  <= 1'b0;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
    end else begin
      if (ctl_wr) begin
        pgm_q   <= wd[`NCSAC_B_PGM];
        cfg_q   <= wd[`NCSAC_B_CFG];
        latch_load_only_q  <= wd[`NCSAC_B_LATCH_LOAD_ONLY];
        erase_q <= wd[`NCSAC_B_ERASE];
        program_erase_enable_q  <= wd[`NCSAC_B_PROGRAM_ERASE_ENABLE];
      end else if (done & (op_q == OP_ERASE)) begin
        erase_q <= 1'b0;
      end
      if (wr_bad | abort) begin
        err_q <= 1'b1;
      end else if (done) begin
        err_q <= 1'b0;
      end else if (ctl_wr) begin
        err_q <= wd[`NCSAC_B_ERR];
      end
      if (wr_ok) begin
        wr_q <= 1'b1;
      end else if (done | abort) begin
        wr_q <= 1'b0;
      end
      rd_q <= rd_req;
    end
  end
  // Self-timed sequencer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      op_q     <= OP_LATCH;
      cnt_q    <= 8'h00;
      op_adr_q <= 15'h0000;
      op_dat_q <= 14'h0000;
      op_cfg_q <= 1'b0;
      halt_q   <= 1'b0;
    end else begin
      halt_q <= halt_d;
      case (state_q)
        ST_IDLE: begin
          if (wr_ok) begin
            state_q  <= ST_BUSY;
            op_q     <= op_sel;
            cnt_q    <= cnt_init;
            op_adr_q <= addr15;
            op_dat_q <= dat14;
            op_cfg_q <= cfg_q;
          end
        end
        ST_BUSY: begin
          if (done | abort) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Write latches
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < `NCSAC_LATCHES; i++) lat[i] <= `NCSAC_ERASED;
    end else if (wr_ok & (op_sel == OP_LATCH | op_sel == OP_PROG)) begin
      lat[slot] <= dat14;
    end else if (done & (op_q == OP_PROG)) begin
      for (int i = 0; i < `NCSAC_LATCHES; i++) lat[i] <= `NCSAC_ERASED;
    end
  end
  // Array updates at completion
  always_ff @(posedge CLK) begin
    if (done & ((op_q == OP_PROG) | (op_q == OP_ERASE))) begin
      for (int i = 0; i < `NCSAC_LATCHES; i++) begin
        if (!op_cfg_q) begin
          prog_mem[{op_adr_q[14:4], 4'(i)}] <= row_word(op_q, lat[i]);
        end else if (cfg_writable({op_adr_q[14:4], 4'(i)})) begin
          uid_mem[2'(i)] <= row_word(op_q, lat[i]);
        end
      end
    end else if (done & (op_q == OP_EE)) begin
      ee_mem[op_adr_q[7:0]] <= op_dat_q[7:0];
    end
  end
  assign PREADY   = pready_q;
  assign PRDATA   = prdata_q;
  assign PSLVERR  = pslverr_q;
  assign CPU_HALT = halt_q;
  // Checks
  sequence s_long_start;
    wr_ok && (op_sel != OP_LATCH);
  endsequence
  sequence s_latch_start;
    wr_ok && (op_sel == OP_LATCH);
  endsequence
  property p_rd_clear;
    @(posedge CLK) disable iff (RST) rd_q |=> !rd_q;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read start not cleared");
  property p_cfg_bad_read;
    @(posedge CLK) disable iff (RST) rd_q && cfg_q && !cfg_ok |=> dat14 == 14'h0000;
  endproperty
  a_cfg_bad_read: assert property (p_cfg_bad_read) else $error("bad config read kept data");
  property p_adrh_fill;
    @(posedge CLK) disable iff (RST) commit && !PWRITE && hit_adrh |-> PRDATA[7];
  endproperty
  a_adrh_fill: assert property (p_adrh_fill) else $error("address high bit 7 not one");
  property p_dath_fill;
    @(posedge CLK) disable iff (RST) commit && !PWRITE && hit_dath |-> PRDATA[7:6] == 2'h0;
  endproperty
  a_dath_fill: assert property (p_dath_fill) else $error("data high top bits not zero");
  property p_locked;
    @(posedge CLK) disable iff (RST) wr_req && !program_erase_enable_q |=> !wr_q && err_q;
  endproperty
  a_locked: assert property (p_locked) else $error("write started while disabled");
  property p_no_key;
    @(posedge CLK) disable iff (RST) wr_req && (key_q != KEY_OPEN) |=> !wr_q;
  endproperty
  a_no_key: assert property (p_no_key) else $error("write started without key");
  property p_wr_hold;
    @(posedge CLK) disable iff (RST) s_long_start |=> (wr_q || !program_erase_enable_q) [*8];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write start dropped early");
  property p_wr_done;
    @(posedge CLK) disable iff (RST) done |=> !wr_q && !err_q && !CPU_HALT;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write start not cleared at end");
  property p_sw_no_clear;
    @(posedge CLK) disable iff (RST)
      ctl_wr && !wd[`NCSAC_B_WR] && wr_q && !done && !abort |=> wr_q;
  endproperty
  a_sw_no_clear: assert property (p_sw_no_clear) else $error("software cleared write start");
  property p_latch_only;
    @(posedge CLK) disable iff (RST) s_latch_start |=> ##1 !wr_q && !busy;
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("latch load ran a write");
  property p_halt;
    @(posedge CLK) disable iff (RST) wr_ok && !is_ee |=> CPU_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("processor not halted");
  property p_erase_clear;
    @(posedge CLK) disable iff (RST) done && (op_q == OP_ERASE) && !ctl_wr |=> !erase_q;
  endproperty
  a_erase_clear: assert property (p_erase_clear) else $error("erase select not cleared");
endmodule // ncsac_top

// ### tb_top.sv
`timescale 1ns/1ps
`include "ncsac_params.svh"
module tb_top;
  localparam logic [13:0] REV  = 14'h0123; // Arbitrary value
  localparam logic [13:0] DEV  = 14'h0b6c; // Arbitrary value
  localparam logic [13:0] CW1  = 14'h2a5a;
  localparam logic [13:0] CW2  = 14'h1c3e;
  localparam logic [11:0] A_DL = `NCSAC_OFF_DATL;
  localparam logic [11:0] A_DH = `NCSAC_OFF_DATH;
  localparam logic [11:0] A_AL = `NCSAC_OFF_ADRL;
  localparam logic [11:0] A_AH = `NCSAC_OFF_ADRH;
  localparam logic [11:0] A_CT = `NCSAC_OFF_CTRL;
  localparam logic [11:0] A_KY = `NCSAC_OFF_KEY;
  localparam logic [7:0]  C_PG = 8'h80;
  localparam logic [7:0]  C_CF = 8'h40;
  localparam logic [7:0]  C_LW = 8'h20;
  localparam logic [7:0]  C_ER = 8'h10;
  localparam logic [7:0]  C_EF = 8'h08;
  localparam logic [7:0]  C_EN = 8'h04;
  localparam logic [7:0]  C_WR = 8'h02;
  localparam logic [7:0]  C_RD = 8'h01;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic        cpu_halt;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        slv;
  logic [13:0] uid_m [4];
  logic [13:0] d1;
  logic [13:0] d2;
  logic [7:0]  ea;
  logic [7:0]  ed;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;
  int          bad [3] = '{4, 9, 15};

  always #12.5 clk = ~clk;

  ncsac_top #(.REV_ID(REV), .DEV_ID(DEV), .CFG_W1(CW1), .CFG_W2(CW2)) u_ncsac_top (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .CPU_HALT(cpu_halt)
  );

  task report_and_stop;
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chk_flag(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s flag got %b", $time, what, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    slv  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e, input string what);
    apb(1'b0, a, 8'h00);
    chk_val(rdat, {24'h0, e}, what);
  endtask

  task start(input logic [7:0] c);
    wr(A_CT, c);
    wr(A_KY, `NCSAC_KEY1);
    wr(A_KY, `NCSAC_KEY2);
    wr(A_CT, c | C_WR);
  endtask

  task wait_done;
    int k;
    k = 0;
    do begin
      apb(1'b0, A_CT, 8'h00);
      k++;
    end while (rdat[1] !== 1'b0 && k < 100);
    chk_flag(rdat[1], 1'b0, "write start clear");
  endtask

  task cfg_read(input logic [3:0] idx, input logic [13:0] e);
    wr(A_AL, {4'h0, idx});
    wr(A_AH, 8'h00);
    wr(A_CT, C_CF | C_EN | C_RD);
    rd(A_DL, e[7:0], "cfg low");
    rd(A_DH, {2'b00, e[13:8]}, "cfg high");
  endtask

  task prog(input logic [3:0] idx, input logic [13:0] d, input logic [7:0] c);
    wr(A_AL, {4'h0, idx});
    wr(A_AH, 8'h00);
    wr(A_DL, d[7:0]);
    wr(A_DH, {2'b00, d[13:8]});
    start(c);
    wait_done();
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(23));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(A_DL, 8'h00, "datl rst");
    rd(A_DH, 8'h00, "dath rst");
    rd(A_AL, 8'h00, "adrl rst");
    rd(A_AH, 8'h80, "adrh rst");
    rd(A_CT, 8'h00, "ctrl rst");
    rd(A_KY, 8'h00, "key rst");
    wr(A_AH, 8'h7f);
    rd(A_AH, 8'hff, "adrh top");
    wr(A_DH, 8'hff);
    rd(A_DH, 8'h3f, "dath top");
    ed = 8'($urandom);
    wr(A_DL, ed);
    rd(A_DL, ed, "datl");
    apb(1'b1, 12'h020, 8'h5a);
    chk_flag(slv, 1'b1, "unmapped wr");
    apb(1'b0, 12'h020, 8'h00);
    chk_flag(slv, 1'b1, "unmapped rd");
    chk_val(rdat, 32'h0, "unmapped data");
    cfg_read(4'h5, REV);
    cfg_read(4'h6, DEV);
    cfg_read(4'h7, CW1);
    cfg_read(4'h8, CW2);
    rd(A_CT, C_CF | C_EN, "read start cleared");
    foreach (bad[i]) begin
      wr(A_DL, 8'($urandom));
      wr(A_DH, 8'($urandom) & 8'h3f);
      cfg_read(4'(bad[i]), 14'h0000);
    end
    start(C_CF);
    rd(A_CT, C_CF | C_EF, "no enable");
    wr(A_CT, C_CF | C_EN);
    wr(A_CT, C_CF | C_EN | C_WR);
    rd(A_CT, C_CF | C_EN | C_EF, "no key");
    wr(A_KY, `NCSAC_KEY2);
    wr(A_KY, `NCSAC_KEY1);
    wr(A_CT, C_CF | C_EN | C_WR);
    rd(A_CT, C_CF | C_EN | C_EF, "key order");
    wr(A_AL, 8'h00);
    start(C_CF | C_ER | C_EN);
    repeat (2) @(posedge clk);
    chk_flag(cpu_halt, 1'b1, "halt busy");
    wr(A_CT, C_CF | C_ER | C_EN);
    rd(A_CT, C_CF | C_ER | C_EN | C_WR, "busy");
    wait_done();
    chk_val(rdat, {24'h0, C_CF | C_EN}, "erase done");
    chk_flag(cpu_halt, 1'b0, "halt done");
    for (int i = 0; i < 4; i++) begin
      uid_m[i] = `NCSAC_ERASED;
      cfg_read(4'(i), uid_m[i]);
    end
    d1 = 14'($urandom);
    d2 = 14'($urandom);
    prog(4'h1, d1, C_CF | C_LW | C_EN);
    cfg_read(4'h1, uid_m[1]);
    prog(4'h2, d2, C_CF | C_EN);
    uid_m[1] = d1;
    uid_m[2] = d2;
    for (int i = 0; i < 4; i++) begin
      cfg_read(4'(i), uid_m[i]);
    end
    prog(4'h6, 14'($urandom), C_CF | C_EN);
    cfg_read(4'h6, DEV);
    prog(4'h7, 14'($urandom), C_CF | C_EN);
    cfg_read(4'h7, CW1);
    prog(4'h3, d1, C_PG | C_EN);
    wr(A_DL, ~d1[7:0]);
    wr(A_CT, C_PG | C_EN | C_RD);
    rd(A_DL, d1[7:0], "flash low");
    rd(A_DH, {2'b00, d1[13:8]}, "flash high");
    ea = 8'($urandom);
    ed = 8'($urandom);
    wr(A_AL, ea);
    wr(A_AH, 8'h00);
    wr(A_DL, ed);
    start(C_LW | C_ER | C_EN);
    wait_done();
    wr(A_DL, ~ed);
    wr(A_CT, C_EN | C_RD);
    rd(A_DL, ed, "eeprom byte");
    wr(A_AL, ea + 8'h01);
    start(C_EN);
    wr(A_CT, 8'h00);
    wait_done();
    chk_flag(rdat[3], 1'b1, "abort error");
    report_and_stop();
  end
endmodule // tb_top
